// ### shared/osd_pkg.sv
// Command codes, field positions, memory sizes and font address layout
// Assumes a 125 MHz system clock and a separate serial link clock
package osd_pkg;
  localparam int CLK_MHZ = 125;
  localparam logic [4:0] CMD_ADDR = 5'h10;
  localparam logic [4:0] CMD_DATA1 = 5'h11;
  localparam logic [4:0] CMD_DATA2 = 5'h12;
  localparam logic [4:0] CMD_FILL = 5'h13;
  localparam logic [4:0] CMD_SCR1 = 5'h14;
  localparam logic [4:0] CMD_SCR2 = 5'h15;
  localparam logic [4:0] CMD_LINE = 5'h16;
  localparam logic [4:0] CMD_VPOS = 5'h17;
  localparam logic [4:0] CMD_HPOS = 5'h18;
  localparam logic [4:0] CMD_MODE = 5'h19;
  localparam logic [4:0] CMD_COLOR = 5'h1a;
  localparam logic [4:0] CMD_SUBCTL = 5'h1b;
  localparam logic [4:0] CMD_SVPOS = 5'h1c;
  localparam logic [4:0] CMD_SHPOS = 5'h1d;
  localparam logic [4:0] CMD_RSV0 = 5'h1e;
  localparam logic [4:0] CMD_RSV1 = 5'h1f;
  localparam int CMD_LSB = 3;
  localparam int BYTE_MSB = 7;
  localparam int ROWS = 12;
  localparam int COLS = 24;
  localparam int LINES = 16;
  localparam int CELLS = ROWS * COLS;
  localparam int RASTER_W = 5;
  localparam int CODE_W = 14;
  localparam int ADDR_W = 21;
  localparam logic [1:0] SEL_LEFT = 2'h0;
  localparam logic [1:0] SEL_CENTER = 2'h1;
  localparam logic [1:0] SEL_RIGHT = 2'h2;
  localparam logic DISPLAY_ON_RESET = 1'b0;
  localparam logic [3:0] READ_CYCLES = 4'h4;
endpackage

// ### shared/osd_byte_if.sv
// Byte hand-over from serial receiver to command decoder
// Assumes the receiver has already crossed into clk_sys
`timescale 1ns/10ps
`default_nettype none
interface osd_byte_if;
  logic valid;
  logic [7:0] data;
  modport rx (output valid, output data);
  modport dec (input valid, input data);
endinterface
`default_nettype wire

// ### hw/osd_serial_rx.sv
// Serial shift receiver on the link clock with a toggle crossing to clk_sys
// Assumes link clock only runs while chip select is low
`timescale 1ns/10ps
`default_nettype none
module osd_serial_rx (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic serial_data_in,
  osd_byte_if.rx out
);
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] shreg, next_shreg;
  logic [7:0] hold, next_hold;
  logic tgl, next_tgl;
  logic [2:0] sync_t;
  logic [7:0] data_q, next_data_q;
  logic valid_q;

  // Link side: frame reset by chip select itself, no edge needed after frame
  always_comb begin
    next_bit_cnt = bit_cnt + 3'h1;
    next_shreg = {shreg[5:0], serial_data_in};
    next_hold = hold;
    next_tgl = tgl;
    if (bit_cnt == 3'h7) begin
      next_hold = {shreg, serial_data_in};
      next_tgl = ~tgl;
    end
  end
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      shreg <= 7'h00;
      hold <= 8'h00;
      tgl <= 1'b0;
    end else begin
      shreg <= next_shreg;
      hold <= next_hold;
      tgl <= next_tgl;
    end
  end
  // Power-up reset too, so the count is never unknown before the first frame
  always_ff @(posedge link_clk or posedge link_cs_n or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 3'h0;
    end else if (link_cs_n) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // Hold is stable for seven link edges after the toggle, ample for sync
  always_comb begin
    next_data_q = data_q;
    if (sync_t[2] != sync_t[1]) begin
      next_data_q = hold;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync_t <= 3'h0;
      data_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      sync_t <= {sync_t[1:0], tgl};
      data_q <= next_data_q;
      valid_q <= sync_t[2] != sync_t[1];
    end
  end
  assign out.valid = valid_q;
  assign out.data = data_q;
endmodule
`default_nettype wire

// ### hw/osd_cmd_decoder.sv
// Command decoder, display memory and font memory port
// Assumes a host on a three-wire serial link and an external font memory
// What this block does
// - Sample eight pulled-up font data lines
// - Drive 21-bit font address, code high bits
// - Selector 00 left, 01 centre, 10 right
// - Main or sub code share address lines
// - Float address and strobe when float low
// - Main character code, attribute and colours
// - Extended graphics reinterprets low data bits
// - Sub line code, colours, graphic, enable
// - Main line phase, pattern, size, background
// - Line command sets size and enables
// - Vertical position and sync output controls
// - Horizontal position and sync input controls
// - Graphics mode and display mode bits
// - Sub vertical position and flag
// - Sub horizontal nine-bit position
// - Reset clears display on bit
// - Address command sets row, column, area
// - Area select and column LSB route data
// - Read strobe low during font read
`timescale 1ns/10ps
`default_nettype none
module osd_cmd_decoder (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic serial_data_in,
  input wire logic [7:0] font_data_in,
  input wire logic font_bus_float_n,
  input wire logic fetch_req,
  input wire logic fetch_sub,
  input wire logic [3:0] fetch_row,
  input wire logic [4:0] fetch_col,
  input wire logic [1:0] fetch_byte,
  input wire logic [4:0] fetch_raster,
  output logic [20:0] font_addr_out,
  output logic [20:0] font_addr_oe,
  output logic font_read_n,
  output logic font_read_oe,
  output logic [7:0] font_byte,
  output logic font_byte_valid,
  output logic [3:0] mem_row_addr,
  output logic [4:0] mem_col_addr,
  output logic mem_area_select,
  output logic display_on_bit,
  output logic [7:0] scr_ctl1,
  output logic [6:0] scr_ctl2,
  output logic [2:0] scr1_hi,
  output logic [2:0] scr2_hi,
  output logic fill_ctl,
  output logic sync_out_ctl,
  output logic simple_std_sel,
  output logic phase_out_en,
  output logic [5:0] main_vert_pos,
  output logic sync_in_select,
  output logic sync_filter_en,
  output logic [5:0] main_horiz_pos,
  output logic ext_graphics_mode,
  output logic [6:0] disp_mode,
  output logic [9:0] color_ctl,
  output logic [8:0] sub_ctl,
  output logic sub_vert_flag,
  output logic [7:0] sub_vert_pos,
  output logic [8:0] sub_horiz_pos,
  output logic [13:0] fetch_code,
  output logic [6:0] fetch_cell_attr,
  output logic [8:0] fetch_line_ctl,
  output logic [13:0] fetch_line_misc,
  output logic cmd_done
);
  osd_byte_if rxb ();

  osd_serial_rx u_rx (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .link_clk(link_clk),
    .link_cs_n(link_cs_n),
    .serial_data_in(serial_data_in),
    .out(rxb)
  );

  typedef enum logic [1:0] {
    OSD_WAIT_FIRST = 2'h1,
    OSD_WAIT_SECOND = 2'h2
  } osd_rx_state_t;

  // Character cell: code[13:0], attr, colour 3, background 3
  logic [13:0] cell_code [osd_pkg::CELLS];
  logic [6:0] cell_attr [osd_pkg::CELLS];
  // Sub line: code, colour 3, graphic, out enable
  logic [13:0] sub_code [osd_pkg::ROWS];
  logic [4:0] sub_ctl_mem [osd_pkg::ROWS];
  // Main line: phase 2, pattern 4 | size 3, prio, vid, dig, bg 4
  logic [5:0] line_a [osd_pkg::LINES];
  logic [9:0] line_b [osd_pkg::LINES];

  osd_rx_state_t st, next_st;
  logic [7:0] first, next_first;
  logic next_exec;
  logic [4:0] code;
  logic [8:0] cell_idx;
  logic [3:0] lidx;

  // First byte waits for its partner; a stray second byte is dropped
  always_comb begin
    next_st = st;
    next_first = first;
    next_exec = 1'b0;
    if (rxb.valid) begin
      if (rxb.data[osd_pkg::BYTE_MSB]) begin
        next_first = rxb.data;
        next_st = OSD_WAIT_SECOND;
      end else if (st == OSD_WAIT_SECOND) begin
        next_exec = 1'b1;
        next_st = OSD_WAIT_FIRST;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= OSD_WAIT_FIRST;
      first <= 8'h00;
    end else begin
      st <= next_st;
      first <= next_first;
    end
  end

  assign code = first[7:osd_pkg::CMD_LSB];
  assign cell_idx = 9'(mem_row_addr * osd_pkg::COLS + mem_col_addr);
  assign lidx = mem_row_addr;

  logic [6:0] b2;
  assign b2 = rxb.data[6:0];
  logic wr_cell1, wr_cell2, wr_sub1, wr_sub2, wr_ln1, wr_ln2;
  logic cell_ok;
  assign cell_ok = (mem_row_addr < 4'(osd_pkg::ROWS)) && (mem_col_addr < 5'(osd_pkg::COLS));
  always_comb begin
    wr_cell1 = 1'b0;
    wr_cell2 = 1'b0;
    wr_sub1 = 1'b0;
    wr_sub2 = 1'b0;
    wr_ln1 = 1'b0;
    wr_ln2 = 1'b0;
    if (next_exec && cell_ok) begin
      if (!mem_area_select) begin
        wr_cell1 = code == osd_pkg::CMD_DATA1;
        wr_cell2 = code == osd_pkg::CMD_DATA2;
      end else if (mem_col_addr[0]) begin
        wr_ln1 = code == osd_pkg::CMD_DATA1;
        wr_ln2 = code == osd_pkg::CMD_DATA2;
      end else begin
        wr_sub1 = code == osd_pkg::CMD_DATA1;
        wr_sub2 = code == osd_pkg::CMD_DATA2;
      end
    end
  end

  // Settings registers, written when the second byte lands
  logic [3:0] n_row;
  logic [4:0] n_col;
  logic n_area, n_dc, n_fill, n_ec, n_lp, n_fo, n_sc, n_fc, n_grm, n_sga;
  logic [7:0] n_s1;
  logic [6:0] n_s2, n_dm;
  logic [2:0] n_s1h, n_s2h;
  logic [5:0] n_vp, n_hp;
  logic [9:0] n_col_ctl;
  logic [8:0] n_sub, n_shp;
  logic [7:0] n_svp;
  always_comb begin
    n_row = mem_row_addr;
    n_col = mem_col_addr;
    n_area = mem_area_select;
    n_dc = display_on_bit;
    n_fill = fill_ctl;
    n_s1 = scr_ctl1;
    n_s1h = scr1_hi;
    n_s2 = scr_ctl2;
    n_s2h = scr2_hi;
    n_ec = sync_out_ctl;
    n_lp = simple_std_sel;
    n_fo = phase_out_en;
    n_vp = main_vert_pos;
    n_sc = sync_in_select;
    n_fc = sync_filter_en;
    n_hp = main_horiz_pos;
    n_grm = ext_graphics_mode;
    n_dm = disp_mode;
    n_col_ctl = color_ctl;
    n_sub = sub_ctl;
    n_sga = sub_vert_flag;
    n_svp = sub_vert_pos;
    n_shp = sub_horiz_pos;
    if (next_exec) begin
      case (code)
        osd_pkg::CMD_ADDR: begin
          n_area = first[2];
          n_row = {first[1:0], b2[6:5]};
          n_col = b2[4:0];
        end
        osd_pkg::CMD_FILL: n_fill = first[2];
        osd_pkg::CMD_SCR1: begin
          n_s1h = first[2:0];
          n_s1 = {1'b0, b2};
          n_dc = b2[0];
        end
        osd_pkg::CMD_SCR2: begin
          n_s2h = first[2:0];
          n_s2 = b2;
        end
        osd_pkg::CMD_VPOS: begin
          n_ec = first[2];
          n_lp = first[1];
          n_fo = first[0];
          n_vp = b2[5:0];
        end
        osd_pkg::CMD_HPOS: begin
          n_sc = first[2];
          n_fc = first[0];
          n_hp = b2[5:0];
        end
        osd_pkg::CMD_MODE: begin
          n_grm = first[0];
          n_dm = b2;
        end
        osd_pkg::CMD_COLOR: n_col_ctl = {first[0], b2, 2'h0};
        osd_pkg::CMD_SUBCTL: n_sub = {first[2:0], b2[5:0]};
        osd_pkg::CMD_SVPOS: begin
          n_sga = first[2];
          n_svp = {first[0], b2};
        end
        osd_pkg::CMD_SHPOS: n_shp = {first[1:0], b2};
        default: n_row = mem_row_addr;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_row_addr <= 4'h0;
      mem_col_addr <= 5'h00;
      mem_area_select <= 1'b0;
      display_on_bit <= osd_pkg::DISPLAY_ON_RESET;
      fill_ctl <= 1'b0;
      scr_ctl1 <= 8'h00;
      scr1_hi <= 3'h0;
      scr_ctl2 <= 7'h00;
      scr2_hi <= 3'h0;
      sync_out_ctl <= 1'b0;
      simple_std_sel <= 1'b0;
      phase_out_en <= 1'b0;
      main_vert_pos <= 6'h00;
      sync_in_select <= 1'b0;
      sync_filter_en <= 1'b0;
      main_horiz_pos <= 6'h00;
      ext_graphics_mode <= 1'b0;
      disp_mode <= 7'h00;
      color_ctl <= 10'h000;
      sub_ctl <= 9'h000;
      sub_vert_flag <= 1'b0;
      sub_vert_pos <= 8'h00;
      sub_horiz_pos <= 9'h000;
      cmd_done <= 1'b0;
    end else begin
      mem_row_addr <= n_row;
      mem_col_addr <= n_col;
      mem_area_select <= n_area;
      display_on_bit <= n_dc;
      fill_ctl <= n_fill;
      scr_ctl1 <= n_s1;
      scr1_hi <= n_s1h;
      scr_ctl2 <= n_s2;
      scr2_hi <= n_s2h;
      sync_out_ctl <= n_ec;
      simple_std_sel <= n_lp;
      phase_out_en <= n_fo;
      main_vert_pos <= n_vp;
      sync_in_select <= n_sc;
      sync_filter_en <= n_fc;
      main_horiz_pos <= n_hp;
      ext_graphics_mode <= n_grm;
      disp_mode <= n_dm;
      color_ctl <= n_col_ctl;
      sub_ctl <= n_sub;
      sub_vert_flag <= n_sga;
      sub_vert_pos <= n_svp;
      sub_horiz_pos <= n_shp;
      cmd_done <= next_exec && (code != osd_pkg::CMD_RSV0) && (code != osd_pkg::CMD_RSV1);
    end
  end

  // Display memory has no reset; the host fills it after power-up
  always_ff @(posedge clk_sys) begin
    if (wr_cell1) begin
      cell_code[cell_idx][11:10] <= {first[1], first[2]};
      cell_code[cell_idx][12] <= b2[3];
      if (ext_graphics_mode) begin
        cell_code[cell_idx][13] <= b2[0];
        cell_attr[cell_idx] <= {first[0], b2[6:4], 1'b0, b2[2:1]};
      end else begin
        cell_attr[cell_idx] <= {first[0], b2[6:4], b2[2:0]};
      end
    end
    if (wr_cell2) begin
      cell_code[cell_idx][9:0] <= {first[2:0], b2};
    end
    if (wr_sub1) begin
      sub_code[lidx][13:10] <= {b2[0], b2[3], first[1], first[2]};
      sub_ctl_mem[lidx] <= {b2[6:4], b2[2:1]};
    end
    if (wr_sub2) begin
      sub_code[lidx][9:0] <= {first[2:0], b2};
    end
    if (wr_ln1) begin
      line_a[lidx] <= {first[2:1], b2[3:0]};
    end
    if (wr_ln2) begin
      // Full ten bits kept; a line command later rewrites only bits 9:4, so background survives
      line_b[lidx] <= {first[2:0], b2};
    end
    if (next_exec && code == osd_pkg::CMD_LINE) begin
      line_b[b2[3:0]][9:4] <= {first[2:0], b2[6:4]};
    end
  end

  // Font fetch: address built from the fetched cell or sub line code
  logic [13:0] n_fcode;
  logic [1:0] sel;
  logic [3:0] rd_cnt, next_rd_cnt;
  logic [20:0] next_addr;
  logic [9:0] fpos;
  logic fetch_done;
  logic [7:0] font_sync1, font_sync2;
  logic float_s1, float_s2;
  assign fpos = 10'(fetch_row * osd_pkg::COLS + fetch_col);
  assign n_fcode = fetch_sub ? sub_code[fetch_row] : cell_code[fpos[8:0]];
  always_comb begin
    case (fetch_byte)
      osd_pkg::SEL_CENTER: sel = 2'b01;
      osd_pkg::SEL_RIGHT: sel = 2'b10;
      default: sel = 2'b00;
    endcase
    next_addr = font_addr_out;
    next_rd_cnt = rd_cnt;
    if (rd_cnt != 4'h0) begin
      next_rd_cnt = rd_cnt - 4'h1;
    end else if (fetch_req) begin
      next_addr = {n_fcode[13:7], sel, n_fcode[6:0], fetch_raster};
      next_rd_cnt = osd_pkg::READ_CYCLES;
    end
  end
  assign fetch_done = rd_cnt == 4'h1;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      font_addr_out <= 21'h000000;
      rd_cnt <= 4'h0;
      font_read_n <= 1'b1;
      font_sync1 <= 8'hff;
      font_sync2 <= 8'hff;
      float_s1 <= 1'b1;
      float_s2 <= 1'b1;
      font_byte <= 8'h00;
      font_byte_valid <= 1'b0;
      fetch_code <= 14'h0000;
      fetch_cell_attr <= 7'h00;
      fetch_line_ctl <= 9'h000;
      fetch_line_misc <= 14'h0000;
    end else begin
      font_addr_out <= next_addr;
      rd_cnt <= next_rd_cnt;
      font_read_n <= next_rd_cnt == 4'h0;
      font_sync1 <= font_data_in;
      font_sync2 <= font_sync1;
      float_s1 <= font_bus_float_n;
      float_s2 <= float_s1;
      font_byte_valid <= fetch_done;
      if (fetch_done) begin
        font_byte <= font_sync2;
      end
      if (fetch_req && rd_cnt == 4'h0) begin
        fetch_code <= n_fcode;
        fetch_cell_attr <= cell_attr[fpos[8:0]];
        fetch_line_ctl <= {sub_ctl_mem[fetch_row], line_b[fetch_row][9:6]};
        fetch_line_misc <= {line_a[fetch_row], line_b[fetch_row][5:0], 2'h0};
      end
    end
  end
  // Float pin lags two cycles through its synchroniser
  assign font_addr_oe = {osd_pkg::ADDR_W{float_s2}};
  assign font_read_oe = float_s2;
endmodule
`default_nettype wire

// ### verification/osd_cmd_decoder_chk.sv
// Checker for the decoder's font port, float control and settings
// Assumes every watched signal lives in the clk_sys domain
`timescale 1ns/10ps
`default_nettype none
module osd_cmd_decoder_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic font_bus_float_n,
  input wire logic [1:0] fetch_byte,
  input wire logic [4:0] fetch_raster,
  input wire logic [20:0] font_addr_out,
  input wire logic [20:0] font_addr_oe,
  input wire logic font_read_n,
  input wire logic font_read_oe,
  input wire logic font_byte_valid,
  input wire logic display_on_bit,
  input wire logic [5:0] main_vert_pos,
  input wire logic [5:0] main_horiz_pos,
  input wire logic [7:0] sub_vert_pos,
  input wire logic [8:0] sub_horiz_pos,
  input wire logic [6:0] disp_mode,
  input wire logic [13:0] fetch_code,
  input wire logic cmd_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // A font read opens with the strobe falling
  sequence s_read_open;
    $fell(font_read_n);
  endsequence
  sequence s_read_body;
    !font_read_n [*4] ##1 font_read_n;
  endsequence
  chk_read_span: assert property (s_read_open |-> s_read_body)
    else $error("read strobe span wrong");
  chk_read_data: assert property (s_read_open |-> ##4 font_byte_valid)
    else $error("font byte not handed over at read end");
  chk_addr_sel: assert property (
    s_read_open |-> font_addr_out[13:12] == $past(fetch_byte))
    else $error("selector bits wrong");
  chk_addr_raster: assert property (
    s_read_open |-> font_addr_out[4:0] == $past(fetch_raster))
    else $error("raster bits wrong");
  chk_code_lines: assert property (
    s_read_open |-> {font_addr_out[20:14], font_addr_out[11:5]} == fetch_code)
    else $error("code bits misplaced on address");
  // Float input passes a synchroniser, so a lag of up to four cycles is allowed
  chk_float_off: assert property (
    (!font_bus_float_n) [*5] |-> font_addr_oe == 21'h000000 && !font_read_oe)
    else $error("font bus still driven while floated");
  chk_float_on: assert property (
    font_bus_float_n [*5] |-> font_addr_oe == 21'h1fffff && font_read_oe)
    else $error("font bus not driven");
  chk_quiet_settings: assert property (
    !$stable({main_vert_pos, main_horiz_pos, sub_vert_pos, sub_horiz_pos, disp_mode,
    display_on_bit}) |-> cmd_done)
    else $error("setting moved without a command");
  chk_disp_reset: assert property ($rose(nrst) |-> !display_on_bit)
    else $error("display on after reset");
endmodule
bind osd_cmd_decoder osd_cmd_decoder_chk chk_u (
  .clk_sys, .nrst, .font_bus_float_n, .fetch_byte, .fetch_raster, .font_addr_out,
  .font_addr_oe, .font_read_n, .font_read_oe, .font_byte_valid, .display_on_bit,
  .main_vert_pos, .main_horiz_pos, .sub_vert_pos, .sub_horiz_pos, .disp_mode,
  .fetch_code, .cmd_done
);
`default_nettype wire

// ### verification/osd_host_model.sv
// Host model that shifts command bytes onto the serial link
// Assumes the decoder samples data on the rising link clock edge
`timescale 1ns/10ps
`default_nettype none
module osd_host_model (
  output logic link_clk,
  output logic link_cs_n,
  output logic serial_data_in
);
  // Clock stands high outside frames, lines rest at pull-up level
  initial begin
    link_clk = 1'b1;
    link_cs_n = 1'b1;
    serial_data_in = 1'b1;
  end
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      link_clk = 1'b0;
      serial_data_in = b[i];
      #3;
      link_clk = 1'b1;
      #3;
    end
  endtask
  // Odd offsets keep link edges away from clk_sys edges
  task automatic frame(input logic [7:0] b1, input logic [7:0] b2, input bit two);
    #2.3;
    link_cs_n = 1'b0;
    shift(b1);
    if (two) begin
      shift(b2);
    end
    #2.3;
    link_cs_n = 1'b1;
    serial_data_in = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verification/osd_command_decoder_font_port_bench.sv
// Testbench for the command decoder and its font memory port
// Assumes the host model drives the link and the checker is bound in
`timescale 1ns/10ps
`default_nettype none
module osd_command_decoder_font_port_bench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic link_clk, link_cs_n, serial_data_in;
  logic [7:0] font_data_in = 8'hff;
  logic font_bus_float_n = 1'b1;
  logic fetch_req = 1'b0;
  logic fetch_sub = 1'b0;
  logic [3:0] fetch_row = 4'h0;
  logic [4:0] fetch_col = 5'h00;
  logic [1:0] fetch_byte = 2'h0;
  logic [4:0] fetch_raster = 5'h00;
  logic [20:0] font_addr_oe;
  logic font_read_n, font_read_oe, font_byte_valid, mem_area_select, display_on_bit;
  logic sync_out_ctl, simple_std_sel, phase_out_en, sync_in_select, sync_filter_en;
  logic ext_graphics_mode, sub_vert_flag, cmd_done;
  logic [7:0] font_byte, sub_vert_pos;
  logic [3:0] mem_row_addr;
  logic [4:0] mem_col_addr;
  logic [5:0] main_vert_pos, main_horiz_pos;
  logic [6:0] disp_mode;
  logic [8:0] sub_horiz_pos;
  logic [13:0] fetch_code, fetch_line_misc;
  logic [6:0] fetch_cell_attr;
  logic [8:0] fetch_line_ctl;
  int err_total = 0;
  int checked = 0;

  always #4 clk_sys = ~clk_sys;

  osd_cmd_decoder dut_u (
    .clk_sys, .nrst, .link_clk, .link_cs_n, .serial_data_in, .font_data_in,
    .font_bus_float_n, .fetch_req, .fetch_sub, .fetch_row, .fetch_col, .fetch_byte,
    .fetch_raster, .font_addr_out(), .font_addr_oe, .font_read_n, .font_read_oe,
    .font_byte, .font_byte_valid, .mem_row_addr, .mem_col_addr, .mem_area_select,
    .display_on_bit, .scr_ctl1(), .scr_ctl2(), .scr1_hi(), .scr2_hi(), .fill_ctl(),
    .sync_out_ctl, .simple_std_sel, .phase_out_en, .main_vert_pos, .sync_in_select,
    .sync_filter_en, .main_horiz_pos, .ext_graphics_mode, .disp_mode, .color_ctl(),
    .sub_ctl(), .sub_vert_flag, .sub_vert_pos, .sub_horiz_pos, .fetch_code,
    .fetch_cell_attr, .fetch_line_ctl, .fetch_line_misc, .cmd_done
  );
  osd_host_model host_u (.link_clk, .link_cs_n, .serial_data_in);

  task automatic stop_test();
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One command frame, then a bounded wait for the done pulse
  task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input bit two, input bit done);
    bit seen;
    seen = 1'b0;
    host_u.frame(b1, b2, two);
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge clk_sys);
      seen = (cmd_done === 1'b1);
    end
    #1;
    cmp("cmd_done", 32'(done), 32'(seen));
    if (done && !seen) begin
      stop_test();
    end
  endtask

  // One font fetch; the byte is read at the valid pulse
  task automatic rd(input logic sub, input logic [3:0] row, input logic [4:0] col,
    input logic [1:0] sel, input logic [13:0] code, input logic [7:0] data);
    bit seen;
    seen = 1'b0;
    tick(1);
    {fetch_sub, fetch_row, fetch_col, fetch_byte} = {sub, row, col, sel};
    fetch_raster = {row, 1'b1};
    font_data_in = data;
    fetch_req = 1'b1;
    tick(1);
    fetch_req = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge clk_sys);
      seen = (font_byte_valid === 1'b1);
    end
    cmp("font_byte_valid", 32'h1, 32'(seen));
    if (!seen) begin
      stop_test();
    end
    cmp("font_byte", data, font_byte);
    cmp("fetch_code", code, fetch_code);
    #1;
    font_data_in = 8'hff;
  endtask

  initial begin
    // Falling edge after time zero so every async reset really fires
    #1;
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    cmp("display_on_bit", 32'h0, display_on_bit);
    cmp("font_read_n", 32'h1, font_read_n);
    cmd(8'ha0, 8'h01, 1, 1);
    cmp("display_on_bit", 32'h1, display_on_bit);
    cmd(8'hbd, 8'h2a, 1, 1);
    cmp("vert", {6'h2a, 3'b101}, {main_vert_pos, sync_out_ctl, simple_std_sel, phase_out_en});
    cmd(8'hc5, 8'h15, 1, 1);
    cmp("horiz", {6'h15, 2'b11}, {main_horiz_pos, sync_in_select, sync_filter_en});
    cmd(8'hc9, 8'h5a, 1, 1);
    cmp("mode", {1'b1, 7'h5a}, {ext_graphics_mode, disp_mode});
    cmd(8'he5, 8'h33, 1, 1);
    cmp("sub_vert", {1'b1, 8'hb3}, {sub_vert_flag, sub_vert_pos});
    cmd(8'heb, 8'h44, 1, 1);
    cmp("sub_horiz", 32'h1c4, sub_horiz_pos);
    // A lone second byte must not reuse the last first byte
    cmd(8'h11, 8'h00, 0, 0);
    cmd(8'hf7, 8'h3f, 1, 0);
    cmd(8'hff, 8'h3f, 1, 0);
    cmp("kept", {6'h2a, 6'h15, 8'hb3, 9'h1c4},
      {main_vert_pos, main_horiz_pos, sub_vert_pos, sub_horiz_pos});
    cmd(8'h80, 8'h45, 1, 1);
    cmp("addr", {1'b0, 4'h2, 5'h05}, {mem_area_select, mem_row_addr, mem_col_addr});
    cmd(8'h8d, 8'h5b, 1, 1);
    cmd(8'h95, 8'h2c, 1, 1);
    for (int s = 0; s < 3; s++) begin
      rd(1'b0, 4'h2, 5'h05, 2'(s), 14'h36ac, 8'ha5 ^ 8'(s));
    end
    cmp("cell_attr", 32'h69, fetch_cell_attr);
    cmd(8'h86, 8'h64, 1, 1);
    cmp("addr", {1'b1, 4'hb, 5'h04}, {mem_area_select, mem_row_addr, mem_col_addr});
    cmd(8'h8a, 8'h2b, 1, 1);
    cmd(8'h93, 8'h11, 1, 1);
    rd(1'b1, 4'hb, 5'h04, 2'h1, 14'h3991, 8'h3c);
    // Odd column routes data writes to main line control
    cmd(8'h86, 8'h65, 1, 1);
    cmd(8'h8a, 8'h0d, 1, 1);
    cmd(8'h95, 8'h5a, 1, 1);
    cmd(8'hb2, 8'h7b, 1, 1);
    rd(1'b1, 4'hb, 5'h05, 2'h2, 14'h3991, 8'h5e);
    cmp("line_ctl", 32'h095, fetch_line_ctl);
    cmp("line_misc", 32'h1de8, fetch_line_misc);
    font_bus_float_n = 1'b0;
    tick(5);
    cmp("float_oe", {21'h000000, 1'b0}, {font_addr_oe, font_read_oe});
    font_bus_float_n = 1'b1;
    tick(5);
    cmp("drive_oe", {21'h1fffff, 1'b1}, {font_addr_oe, font_read_oe});
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    cmp("display_on_bit", 32'h0, display_on_bit);
    stop_test();
  end
endmodule
`default_nettype wire
